// ===== hw/phid_pkg.sv
// Shared constants and types of the parallel host port with type detection
package phid_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    // Internal reset phase after reset_powerdown falls
    localparam int RST_PHASE_NS = 1000;
    localparam logic [7:0] RST_PHASE_CYC =
        8'((RST_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Host: least high time of reset_powerdown
    localparam int HOST_PD_NS = 100;
    localparam logic [7:0] HOST_PD_CYC =
        8'((HOST_PD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Host: least wait after reset_powerdown falls, covers the reset phase
    localparam int HOST_WAIT_NS = 1200;
    localparam logic [7:0] HOST_WAIT_CYC =
        8'((HOST_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Host: cycles of each bus phase
    localparam logic [7:0] HOST_PHASE_CYC = 8'h04;
    // Device: busy cycles before the handshake wait line ends a cycle
    localparam logic [1:0] HS_LATENCY = 2'h2;

    // ------------------------------------------------------------------
    // Bus widths and fixed values
    // ------------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int ADDR_W = 6;
    localparam logic [DATA_W-1:0] BUS_IDLE = 8'hff;
    localparam logic [DATA_W-1:0] INIT_DATA = 8'h00;
    localparam logic [2:0] DED_ADDR_PAD = 3'h0;
    localparam logic [1:0] MUX_ADDR_PAD = 2'h0;

    // ------------------------------------------------------------------
    // Interface modes, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [6:0] {
        MODE_NONE    = 7'h01,  // Not yet identified
        MODE_DED_PND = 7'h02,  // Dedicated address, strobe style pending
        MODE_DED_SEP = 7'h04,  // Dedicated address, separate strobes
        MODE_DED_SHR = 7'h08,  // Dedicated address, shared strobe
        MODE_MUX_SEP = 7'h10,  // Multiplexed, separate strobes
        MODE_MUX_SHR = 7'h20,  // Multiplexed, shared strobe
        MODE_HSHK    = 7'h40   // Multiplexed with handshake
    } phid_mode_e;

endpackage

// ===== hw/phid_if.sv
// Pin bundle between host and device ends of the parallel port
`timescale 1ns/1ps
`default_nettype none
interface phid_if;
    import phid_pkg::*;

    logic reset_powerdown;
    logic chip_select_n;
    logic rd_pin;               // read_strobe_n, data_strobe_n or handshake data strobe
    logic wr_pin;               // write_strobe_n, read_not_write or handshake write
    logic ale_pin;              // addr_latch_enable, addr_strobe_hi, handshake addr strobe
    logic addr2;
    logic addr1;
    logic addr0_o;              // Host drive of addr0
    logic addr0_oe;
    logic nwait_o;              // Device wait line on the addr0 pin
    logic nwait_oe;
    logic [DATA_W-1:0] host_d_o;
    logic host_d_oe;
    logic [DATA_W-1:0] dev_d_o;
    logic dev_d_oe;
    logic addr0;                // Resolved pin level
    logic [DATA_W-1:0] data;    // Resolved bus level

    // Wire resolution, pulled high when nobody drives
    assign addr0 = nwait_oe ? nwait_o : (addr0_oe ? addr0_o : 1'b1);
    assign data = dev_d_oe ? dev_d_o : (host_d_oe ? host_d_o : BUS_IDLE);

    modport dev (
        input reset_powerdown, chip_select_n, rd_pin, wr_pin, ale_pin,
        input addr2, addr1, addr0, data,
        output nwait_o, nwait_oe, dev_d_o, dev_d_oe
    );
    modport host (
        output reset_powerdown, chip_select_n, rd_pin, wr_pin, ale_pin,
        output addr2, addr1, addr0_o, addr0_oe, host_d_o, host_d_oe,
        input addr0, data
    );
endinterface
`default_nettype wire

// ===== hw/phid_host.sv
// Host end: drives straps, hard reset, init routine and bus accesses
`timescale 1ns/1ps
`default_nettype none
module phid_host import phid_pkg::*; (
    input wire logic ref_clk,                 // 125 MHz clock
    input wire logic resetn,                  // Async reset, active low
    phid_if.host pins,                        // Parallel port pins
    input wire phid_mode_e mode_sel,          // Wiring style of this board
    input wire logic hard_reset,              // Pulse: request a hard reset
    input wire logic cmd_valid,               // Access request
    input wire logic cmd_write,               // 1 write, 0 read
    input wire logic [ADDR_W-1:0] cmd_addr,   // Register address
    input wire logic [DATA_W-1:0] cmd_wdata,  // Write data
    output logic cmd_ready,                   // Request taken when valid
    output logic rsp_valid,                   // Pulse: access done
    output logic [DATA_W-1:0] rsp_rdata       // Read data
);

    typedef enum logic [6:0] {
        H_PD   = 7'h01,
        H_WAIT = 7'h02,
        H_IDLE = 7'h04,
        H_ADDR = 7'h08,
        H_GAP  = 7'h10,
        H_STB  = 7'h20,
        H_END  = 7'h40
    } phid_hst_e;

    phid_hst_e state_r;
    logic [7:0] cnt_r;
    logic init_pend_r;
    logic op_write_r;
    logic [ADDR_W-1:0] op_addr_r;
    logic [DATA_W-1:0] op_data_r;
    logic rsp_valid_r;
    logic [DATA_W-1:0] rsp_rdata_r;
    logic is_ded, is_mux, is_sep, is_hs, busy, phase_done;

    assign is_ded = (mode_sel == MODE_DED_SEP) || (mode_sel == MODE_DED_SHR);
    assign is_mux = (mode_sel == MODE_MUX_SEP) || (mode_sel == MODE_MUX_SHR) || is_hs;
    assign is_sep = (mode_sel == MODE_DED_SEP) || (mode_sel == MODE_MUX_SEP);
    assign is_hs = (mode_sel == MODE_HSHK);
    assign busy = (state_r == H_ADDR) || (state_r == H_GAP) || (state_r == H_STB);
    // Handshake phases also wait for the device to end the cycle
    assign phase_done = (cnt_r == 8'h00) && (!is_hs || pins.addr0);

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= H_PD;
            cnt_r <= HOST_PD_CYC;
        end else if (hard_reset) begin
            state_r <= H_PD;
            cnt_r <= HOST_PD_CYC;
        end else begin
            if (cnt_r != 8'h00) begin
                cnt_r <= cnt_r - 8'h01;
            end
            unique case (state_r)
                H_PD: if (cnt_r == 8'h00) begin
                    state_r <= H_WAIT;
                    cnt_r <= HOST_WAIT_CYC;
                end
                H_WAIT: if (cnt_r == 8'h00) begin
                    state_r <= H_IDLE;
                end
                H_IDLE: if (init_pend_r || (cmd_valid && cmd_ready)) begin
                    state_r <= is_mux ? H_ADDR : H_GAP;
                    cnt_r <= HOST_PHASE_CYC;
                end
                H_ADDR: if (phase_done && !(is_hs && !pins.addr0)) begin
                    state_r <= H_GAP;
                    cnt_r <= HOST_PHASE_CYC;
                end
                H_GAP: if (cnt_r == 8'h00) begin
                    state_r <= H_STB;
                    cnt_r <= HOST_PHASE_CYC;
                end
                H_STB: if (phase_done) begin
                    state_r <= H_END;
                    cnt_r <= HOST_PHASE_CYC;
                end
                H_END: if (cnt_r == 8'h00) begin
                    state_r <= H_IDLE;
                end
            endcase
        end
    end

    // Init routine pending after each hard reset on dedicated wiring
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            init_pend_r <= 1'b0;
        end else if (state_r == H_WAIT && cnt_r == 8'h00) begin
            init_pend_r <= is_ded;
        end else if (state_r == H_IDLE) begin
            init_pend_r <= 1'b0;
        end
    end

    // Operation latch; init routine is a dummy write
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            op_write_r <= 1'b0;
            op_addr_r <= '0;
            op_data_r <= '0;
        end else if (state_r == H_IDLE) begin
            op_write_r <= init_pend_r ? 1'b1 : cmd_write;
            op_addr_r <= init_pend_r ? '0 : cmd_addr;
            op_data_r <= init_pend_r ? INIT_DATA : cmd_wdata;
        end
    end

    // Read capture and completion pulse
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rsp_valid_r <= 1'b0;
            rsp_rdata_r <= '0;
        end else begin
            rsp_valid_r <= (state_r == H_END) && (cnt_r == 8'h00);
            if (state_r == H_STB && phase_done && !op_write_r) begin
                rsp_rdata_r <= pins.data;
            end
        end
    end

    assign cmd_ready = (state_r == H_IDLE) && !init_pend_r;
    assign rsp_valid = rsp_valid_r;
    assign rsp_rdata = rsp_rdata_r;

    // ------------------------------------------------------------------
    // Pin drive per wiring style
    // ------------------------------------------------------------------
    assign pins.reset_powerdown = (state_r == H_PD);
    assign pins.chip_select_n = is_hs ? 1'b0 : !busy;
    // Address phase on ale pin: high pulse, or low for handshake
    assign pins.ale_pin = is_ded ? 1'b1 : (is_hs ? (state_r != H_ADDR) : (state_r == H_ADDR));
    assign pins.addr2 = is_ded ? op_addr_r[2] : is_hs;
    assign pins.addr1 = is_ded ? op_addr_r[1] : 1'b1;
    assign pins.addr0_o = is_ded ? op_addr_r[0] : (mode_sel == MODE_MUX_SEP);
    assign pins.addr0_oe = !is_hs;
    // Separate style pulses one strobe; shared styles set direction first
    assign pins.rd_pin = is_sep ? !(state_r == H_STB && !op_write_r) : (state_r != H_STB);
    assign pins.wr_pin = is_sep ? !(state_r == H_STB && op_write_r) : !(busy && op_write_r);
    // Bus carries address phase then write data
    assign pins.host_d_o = (state_r == H_ADDR) ? {MUX_ADDR_PAD, op_addr_r} : op_data_r;
    assign pins.host_d_oe = (state_r == H_ADDR) || (op_write_r && (state_r == H_GAP || state_r == H_STB));

endmodule
`default_nettype wire

// ===== hw/phid_device.sv
// Device end: interface type detection, address latching and accesses
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Dedicated modes: data over 8-bit two-way bus
// - Multiplexed modes: one bus, address then data
// - Mux separate: latch address while latch enable high
// - Mux shared: latch address while strobe high
// - Handshake: latch address while address strobe low
// - Handshake: wait low starts, high ends cycle
// - Dedicated: three address pins form address bits
// - Powerdown high: oscillator off, pads and sinks off
// - Powerdown falling edge starts reset phase
// - Every reset clears mode, detects it again
// - Type taken from pin levels after reset
// - Host init routine resolves strap ambiguity
// - Board straps pins for each style
// - Separate style uses read, write, select strobes
// - Shared style uses direction, data strobe, select
// - Handshake is multiplexed only, wait on addr0
// - Host selects device with chip select low
// - Separate style: pulse write or read strobe
// - Shared style: set direction, then pulse strobe
// - Wait line undriven until first address strobe
module phid_device import phid_pkg::*; (
    input wire logic ref_clk,                 // 125 MHz clock
    input wire logic resetn,                  // Async reset, active low
    phid_if.dev pins,                         // Parallel port pins
    output logic [ADDR_W-1:0] reg_addr,       // Register address
    output logic [DATA_W-1:0] reg_wdata,      // Write data
    output logic reg_wr,                      // Pulse: register write
    output logic reg_rd,                      // Pulse: register read
    input wire logic [DATA_W-1:0] reg_rdata,  // Read data, valid with reg_rd
    output phid_mode_e mode,                  // Detected interface type
    output logic in_reset,                    // Reset phase running
    output logic osc_en,                      // Oscillator enable
    output logic sink_en                      // Internal current sinks enable
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    phid_mode_e mode_r;
    logic pd;
    logic [7:0] rst_cnt_r;
    logic cs_n, rd_n, wr_n, ale, a2, a1, a0;
    logic [DATA_W-1:0] din;
    logic [DATA_W-1:0] d_prev_r;
    logic is_sep, is_shr, is_mux, active;
    logic stb, is_read, stb_start, stb_end;
    logic stb_prev_r, read_prev_r;
    logic [ADDR_W-1:0] addr_r;
    logic reg_wr_r, reg_rd_r;
    logic [DATA_W-1:0] wdata_r, dout_r;
    logic pend_wr_r, pend_rd_r, pend_wr;
    logic ast_prev_r, nwait_en_r;
    logic hs_busy;
    logic [1:0] hs_cnt_r;

    // ------------------------------------------------------------------
    // Power-down and pad isolation
    // ------------------------------------------------------------------
    assign pd = pins.reset_powerdown;
    assign osc_en = !pd;
    assign sink_en = !pd;
    // Disconnected pads read as idle levels
    assign cs_n = pd | pins.chip_select_n;
    assign rd_n = pd | pins.rd_pin;
    assign wr_n = pd | pins.wr_pin;
    assign ale = !pd & pins.ale_pin;
    assign a2 = !pd & pins.addr2;
    assign a1 = !pd & pins.addr1;
    assign a0 = !pd & pins.addr0;
    assign din = pd ? BUS_IDLE : pins.data;

    // ------------------------------------------------------------------
    // Reset phase
    // ------------------------------------------------------------------
    // Counter held full while powered down, runs once it falls
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_cnt_r <= RST_PHASE_CYC;
        end else if (pd) begin
            rst_cnt_r <= RST_PHASE_CYC;
        end else if (rst_cnt_r != 8'h00) begin
            rst_cnt_r <= rst_cnt_r - 8'h01;
        end
    end
    assign in_reset = (rst_cnt_r != 8'h00);

    // ------------------------------------------------------------------
    // Interface type detection
    // ------------------------------------------------------------------
    // Strap decode of the control pins
    function automatic phid_mode_e strap_decode(
        input logic s_ale, input logic s_a2, input logic s_a1,
        input logic s_a0, input logic s_cs_n);
        phid_mode_e m;
        m = MODE_NONE;
        // Handshake address strobe idles high, so its straps win first
        if (s_a2 && s_a1 && !s_cs_n) begin
            m = MODE_HSHK;
        end else if (s_ale) begin
            m = MODE_DED_PND;
        end else if (!s_a2 && s_a1) begin
            m = s_a0 ? MODE_MUX_SEP : MODE_MUX_SHR;
        end
        return m;
    endfunction

    // Dedicated style resolved by the init write: shared strobe shows
    // the read pin low while the write pin is low
    assign pend_wr = !cs_n && !wr_n;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pend_wr_r <= 1'b0;
            pend_rd_r <= 1'b0;
        end else if (mode_r != MODE_DED_PND) begin
            pend_wr_r <= 1'b0;
            pend_rd_r <= 1'b0;
        end else begin
            pend_wr_r <= pend_wr;
            pend_rd_r <= pend_wr ? (pend_rd_r | !rd_n) : 1'b0;
        end
    end

    // Mode cleared in reset, sampled when the phase ends
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mode_r <= MODE_NONE;
        end else if (in_reset) begin
            mode_r <= MODE_NONE;
            if (rst_cnt_r == 8'h01 && !pd) begin
                mode_r <= strap_decode(ale, a2, a1, a0, cs_n);
            end
        end else if (mode_r == MODE_DED_PND && pend_wr_r && !pend_wr) begin
            mode_r <= pend_rd_r ? MODE_DED_SHR : MODE_DED_SEP;
        end
    end
    assign mode = mode_r;

    // ------------------------------------------------------------------
    // Strobe decode per style
    // ------------------------------------------------------------------
    assign is_sep = (mode_r == MODE_DED_SEP) || (mode_r == MODE_MUX_SEP);
    assign is_shr = (mode_r == MODE_DED_SHR) || (mode_r == MODE_MUX_SHR) ||
                    (mode_r == MODE_HSHK);
    assign is_mux = (mode_r == MODE_MUX_SEP) || (mode_r == MODE_MUX_SHR) ||
                    (mode_r == MODE_HSHK);
    assign active = (is_sep || is_shr) && !in_reset;

    // Chip select also gates the handshake data strobe
    always_comb begin
        stb = 1'b0;
        is_read = 1'b0;
        if (is_sep) begin
            stb = !cs_n && (!rd_n || !wr_n);
            is_read = !rd_n;
        end else if (is_shr) begin
            stb = !cs_n && !rd_n;
            is_read = wr_n;
        end
    end
    assign stb_start = active && stb && !stb_prev_r;
    assign stb_end = active && !stb && stb_prev_r;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            stb_prev_r <= 1'b0;
            read_prev_r <= 1'b0;
            d_prev_r <= '0;
        end else begin
            stb_prev_r <= active && stb;
            read_prev_r <= is_read;
            d_prev_r <= din;
        end
    end

    // ------------------------------------------------------------------
    // Address latch
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            addr_r <= '0;
        end else if (in_reset) begin
            addr_r <= '0;
        end else if (!is_mux && stb_start) begin
            addr_r <= {DED_ADDR_PAD, a2, a1, a0};
        end else if ((mode_r == MODE_MUX_SEP) && ale) begin
            addr_r <= din[ADDR_W-1:0];
        end else if ((mode_r == MODE_MUX_SHR) && ale) begin
            addr_r <= din[ADDR_W-1:0];
        end else if ((mode_r == MODE_HSHK) && !ale) begin
            addr_r <= din[ADDR_W-1:0];
        end
    end
    assign reg_addr = addr_r;

    // ------------------------------------------------------------------
    // Register accesses
    // ------------------------------------------------------------------
    // Read issued at strobe start, write committed at strobe end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rd_r <= 1'b0;
            reg_wr_r <= 1'b0;
            wdata_r <= '0;
        end else begin
            reg_rd_r <= stb_start && is_read;
            reg_wr_r <= stb_end && !read_prev_r;
            if (stb_end && !read_prev_r) begin
                wdata_r <= d_prev_r;
            end
        end
    end
    assign reg_rd = reg_rd_r;
    assign reg_wr = reg_wr_r;
    assign reg_wdata = wdata_r;

    // Read data held for the rest of the strobe
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dout_r <= '0;
        end else if (reg_rd_r) begin
            dout_r <= reg_rdata;
        end
    end
    assign pins.dev_d_o = dout_r;
    assign pins.dev_d_oe = active && stb && is_read && stb_prev_r;

    // ------------------------------------------------------------------
    // Handshake wait line
    // ------------------------------------------------------------------
    // Enabled by the first address strobe fall after reset
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ast_prev_r <= 1'b1;
            nwait_en_r <= 1'b0;
        end else if (in_reset || pd) begin
            ast_prev_r <= 1'b1;
            nwait_en_r <= 1'b0;
        end else begin
            ast_prev_r <= ale;
            if (mode_r == MODE_HSHK && ast_prev_r && !ale) begin
                nwait_en_r <= 1'b1;
            end
        end
    end

    // Busy cycles counted; high once data or address is taken
    assign hs_busy = (mode_r == MODE_HSHK) && (!ale || (stb && stb_prev_r));
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            hs_cnt_r <= 2'h0;
        end else if (!hs_busy) begin
            hs_cnt_r <= 2'h0;
        end else if (hs_cnt_r != HS_LATENCY) begin
            hs_cnt_r <= hs_cnt_r + 2'h1;
        end
    end
    assign pins.nwait_o = (hs_cnt_r == HS_LATENCY);
    assign pins.nwait_oe = nwait_en_r && (mode_r == MODE_HSHK);

endmodule
`default_nettype wire

// ===== bench/phid_chk.sv
// Pin-level assertions on the link between host and device ends
`timescale 1ns/1ps
`default_nettype none
module phid_chk import phid_pkg::*; (
    input wire logic ref_clk, // Clock
    input wire logic resetn, // Reset, low
    input wire logic reset_powerdown, // Hard reset pin
    input wire logic chip_select_n, // Select, low
    input wire logic rd_pin, // Data strobe
    input wire logic wr_pin, // Write or direction
    input wire logic ale_pin, // Address strobe
    input wire logic nwait_o, // Wait level
    input wire logic nwait_oe, // Wait drive
    input wire logic host_d_oe, // Host bus drive
    input wire logic [DATA_W-1:0] dev_d_o, // Device bus data
    input wire logic dev_d_oe // Device bus drive
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic seen_r;
    // ------------------------------------------------
    // Address strobe fall seen since hard reset
    // ------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) seen_r <= 1'b0;
        else if (reset_powerdown) seen_r <= 1'b0;
        else if ($fell(ale_pin)) seen_r <= 1'b1;
    end
    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    property p_pd_quiet; reset_powerdown |-> !dev_d_oe; endproperty
    a_pd_quiet: assert property (p_pd_quiet) else $error("bus driven in power-down");
    property p_rd_only; dev_d_oe |-> !chip_select_n && !rd_pin && wr_pin; endproperty
    a_rd_only: assert property (p_rd_only) else $error("bus driven outside read");
    property p_no_clash; dev_d_oe |-> !host_d_oe; endproperty
    a_no_clash: assert property (p_no_clash) else $error("both ends drive bus");
    property p_oe_late; $rose(dev_d_oe) |-> !$past(rd_pin); endproperty
    a_oe_late: assert property (p_oe_late) else $error("drive before strobe");
    // First driven cycle still shows the previous read, so skip it
    property p_hold;
        dev_d_oe && $past(dev_d_oe) && $past(dev_d_oe, 2) |-> $stable(dev_d_o);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_wfirst; nwait_oe && !reset_powerdown && !$past(reset_powerdown) |-> seen_r; endproperty
    a_wfirst: assert property (p_wfirst) else $error("wait driven early");
    property p_wstart; nwait_oe && $fell(rd_pin) |-> ##[1:3] nwait_o; endproperty
    a_wstart: assert property (p_wstart) else $error("wait never high");
    property p_wend; nwait_oe && $rose(rd_pin) |-> ##[0:3] !nwait_o; endproperty
    a_wend: assert property (p_wend) else $error("wait never low");
    c_read: cover property ($rose(dev_d_oe));
    c_wait: cover property (nwait_oe && $rose(nwait_o));
    c_pd: cover property ($fell(reset_powerdown));
endmodule
`default_nettype wire

// ===== bench/phid_tb.sv
// Bench joining both port ends across every wiring style
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import phid_pkg::*;
    typedef struct packed {
        phid_mode_e mode;
        logic [5:0] addr;
        logic [7:0] wdata;
        logic [5:0] exp_addr;
    } phid_row_s;
    localparam phid_row_s ROWS [5] = '{'{MODE_DED_SEP, 6'h3d, 8'ha5, 6'h05},
        '{MODE_DED_SHR, 6'h2a, 8'h5a, 6'h02}, '{MODE_MUX_SEP, 6'h3f, 8'hc3, 6'h3f},
        '{MODE_MUX_SHR, 6'h15, 8'h3c, 6'h15}, '{MODE_HSHK, 6'h2e, 8'h81, 6'h2e}};
    logic ref_clk = 0, resetn = 0, hard_reset = 0, cmd_valid = 0, cmd_write = 0;
    logic [5:0] cmd_addr = 6'h00, reg_addr, wr_addr;
    logic [7:0] cmd_wdata = 8'h00, reg_wdata, reg_rdata, rsp_rdata, wr_data;
    logic cmd_ready, rsp_valid, reg_wr, reg_rd, in_reset, osc_en, sink_en;
    phid_mode_e mode_sel = MODE_DED_SEP, mode;
    int n_fail = 0, samples_checked = 0, i, r;
    phid_if u_phid_if();
    phid_host u_phid_host(.ref_clk(ref_clk), .resetn(resetn), .pins(u_phid_if),
        .mode_sel(mode_sel), .hard_reset(hard_reset), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
    phid_device u_phid_device(.ref_clk(ref_clk), .resetn(resetn), .pins(u_phid_if),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .mode(mode), .in_reset(in_reset), .osc_en(osc_en),
        .sink_en(sink_en));
    phid_chk u_phid_chk(.ref_clk(ref_clk), .resetn(resetn), .wr_pin(u_phid_if.wr_pin),
        .reset_powerdown(u_phid_if.reset_powerdown), .rd_pin(u_phid_if.rd_pin),
        .chip_select_n(u_phid_if.chip_select_n), .ale_pin(u_phid_if.ale_pin),
        .nwait_o(u_phid_if.nwait_o), .nwait_oe(u_phid_if.nwait_oe),
        .host_d_oe(u_phid_if.host_d_oe), .dev_d_o(u_phid_if.dev_d_o),
        .dev_d_oe(u_phid_if.dev_d_oe));
    // Register file stand-in and write capture
    assign reg_rdata = {2'h3, reg_addr};
    always @(posedge ref_clk) begin
        if (reg_wr) wr_addr <= reg_addr;
        if (reg_wr) wr_data <= reg_wdata;
    end
    initial forever #4 ref_clk = ~ref_clk;
    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    task print_verdict;
        $display("Checked %0d, failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task tick;
        @(negedge ref_clk);
        if (++i > 3000) begin
            n_fail++;
            $display("[FAIL] wait expected done seen timeout");
            print_verdict();
        end
    endtask
    task access(input logic wr, input logic [5:0] a, input logic [7:0] d);
        for (i = 0; cmd_ready !== 1'b1;) tick();
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_addr = a;
        cmd_wdata = d;
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        for (i = 0; rsp_valid !== 1'b1;) tick();
    endtask
    task hard_pulse;
        hard_reset = 1'b1;
        @(negedge ref_clk);
        hard_reset = 1'b0;
        @(negedge ref_clk);
    endtask
    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        repeat (5) @(negedge ref_clk);
        resetn = 1'b1;
        for (r = 0; r < 5; r++) begin
            mode_sel = ROWS[r].mode;
            hard_pulse();
            for (i = 0; cmd_ready !== 1'b1;) tick();
            check("mode", mode, ROWS[r].mode);
            access(1'b1, ROWS[r].addr, ROWS[r].wdata);
            check("wr_addr", wr_addr, ROWS[r].exp_addr);
            check("wr_data", wr_data, ROWS[r].wdata);
            access(1'b0, ROWS[r].addr, 8'h00);
            check("rd_data", rsp_rdata, {2'h3, ROWS[r].exp_addr});
            $display("Row %0d done", r);
        end
        // Power-down levels, then reset phase after the pin falls
        hard_pulse();
        for (i = 0; u_phid_if.reset_powerdown !== 1'b1;) tick();
        check("osc_en", osc_en, 1'b0);
        check("sink_en", sink_en, 1'b0);
        for (i = 0; u_phid_if.reset_powerdown !== 1'b0;) tick();
        @(negedge ref_clk);
        check("in_reset", in_reset, 1'b1);
        check("mode", mode, MODE_NONE);
        check("nwait_oe", u_phid_if.nwait_oe, 1'b0);
        access(1'b0, 6'h21, 8'h00);
        check("rd_data", rsp_rdata, 8'he1);
        $display("Power-down test done");
        // Mid-access asynchronous reset
        cmd_valid = 1'b1;
        repeat (6) @(negedge ref_clk);
        resetn = 1'b0;
        cmd_valid = 1'b0;
        @(negedge ref_clk);
        check("mode", mode, MODE_NONE);
        check("dev_d_oe", u_phid_if.dev_d_oe, 1'b0);
        $display("Reset test done");
        print_verdict();
    end
endmodule
`default_nettype wire
